// ---- design/sfh_pkg.sv ----
package sfh_pkg;

    // ----------------------------------------------------------------
    // Command opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] CMD_WRITE_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] CMD_IDENTITY_READ = 8'h9F;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_PARALLEL = 8'h55;
    localparam logic [7:0] CMD_SECTOR_WIPE_A = 8'h20;
    localparam logic [7:0] CMD_SECTOR_WIPE_B = 8'hD8;
    localparam logic [7:0] CMD_CHIP_WIPE_A = 8'h60;
    localparam logic [7:0] CMD_CHIP_WIPE_B = 8'hC7;
    localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
    localparam logic [7:0] CMD_SLEEP = 8'hB9;
    localparam logic [7:0] CMD_PARAM_SECTOR_ENTER = 8'hA5;
    localparam logic [7:0] CMD_PARAM_SECTOR_EXIT = 8'hB5;
    localparam logic [7:0] CMD_WAKE = 8'hAB;
    localparam logic [7:0] CMD_MAKER_DEVICE_IDENTITY = 8'h90;

    // ----------------------------------------------------------------
    // Header lengths, order select, address map
    // ----------------------------------------------------------------
    localparam logic [2:0] HDR_NONE = 3'h0;
    localparam logic [2:0] HDR_ADDR = 3'h3;
    localparam logic [2:0] HDR_FAST = 3'h4;
    localparam logic [7:0] ORDER_DEVICE_FIRST = 8'h01;
    localparam logic [21:0] ADDR_STEP = 22'h1;
    localparam int SECTOR_MSB = 21;
    localparam int SECTOR_LSB = 16;

    // ----------------------------------------------------------------
    // Pin synchroniser layout and reset values
    // ----------------------------------------------------------------
    localparam int PIN_COUNT = 5;
    localparam int PIN_CS = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_PAUSE = 3;
    localparam int PIN_ACCEL = 4;
    localparam logic [4:0] PIN_RESET = 5'h09;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [23:0] ADDR_RESET = 24'h00_0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPC = 3'b001,
        ST_HDR = 3'b010,
        ST_IN = 3'b011,
        ST_OUT = 3'b100,
        ST_BAD = 3'b101
    } sfh_state_t;

endpackage

// ---- design/sfh_pins_if.sv ----
`timescale 1ns/1ns
interface sfh_pins_if #(
    parameter int N = 5
);
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport src(output lvl, output rise, output fall);
    modport dst(input lvl, input rise, input fall);
endinterface

// ---- design/sfh_pin_sync.sv ----
`timescale 1ns/1ns
module sfh_pin_sync
    import sfh_pkg::*;
#(
    parameter int N = PIN_COUNT
) (
    input wire logic i_mclk, // System clock
    input wire logic i_reset_n, // Sync reset, active low
    input wire logic [N-1:0] i_pins, // Raw pins from the host
    sfh_pins_if.src pins // Synced levels and edges
);
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;

    // Two-stage synchroniser plus one delay stage for edges
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            meta <= N'(PIN_RESET);
            sync <= N'(PIN_RESET);
            prev <= N'(PIN_RESET);
        end else begin
            meta <= i_pins;
            sync <= meta;
            prev <= sync;
        end
    end

    // Edge detection looks only at settled stages
    assign pins.lvl = sync;
    assign pins.rise = sync & ~prev;
    assign pins.fall = ~sync & prev;
endmodule

// ---- design/sfh_flash_front.sv ----
// How it works
// RULE1: Pause stops only serial traffic; running program or erase goes on.
// RULE2: Pause starts on pause fall with select low, deferred until clock low.
// RULE3: Pause ends on pause rise, deferred until the serial clock is low.
// RULE4: While paused, data out floats and clock and data in are ignored.
// RULE5: Select rising during pause resets the interface and drops the command.
// RULE6: Host raises pause before selecting again after such an abort.
// RULE7: Host should avoid pause while in parallel mode.
// RULE8: Host raises the accel pin before issuing program or erase.
// RULE9: Latch set, latch clear, identity, status read and status write opcodes.
// RULE10: Read, fast read with one dummy, and sticky parallel mode entry.
// RULE11: Sector and chip wipe each accept two opcode values.
// RULE12: Page write with address; sleep and parameter sector enter and exit.
// RULE13: Wake shares opcode with short identity; maker identity takes order.
// RULE14: Order byte zero gives maker code first, one gives device code first.
// RULE15: Array splits into 64 sectors of 64K bytes by address bits 21..16.
// RULE16: Inputs sampled on clock rise, outputs shifted on clock fall.
// RULE17: Listed commands run only if select rises on a byte boundary.
// RULE18: All bytes travel MSB first; first address byte is the highest.
// RULE19: Unknown opcodes are ignored and output floats until deselect.
`timescale 1ns/1ns
module sfh_flash_front
    import sfh_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEVICE_TYPE = 8'h11, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h22, // Arbitrary value
    parameter logic [7:0] SHORT_ID = 8'h33 // Arbitrary value
) (
    input wire logic i_mclk, // System clock
    input wire logic i_reset_n, // Sync reset, active low
    input wire logic i_cs_n, // Chip select pin, active low
    input wire logic i_sclk, // Serial clock pin
    input wire logic i_si, // Serial data in pin
    input wire logic i_pause_n, // Pause pin, active low
    input wire logic i_protect_accel_pin, // High at accel voltage
    input wire logic i_busy, // Program or erase running
    input wire logic [7:0] i_status, // Status byte to send
    input wire logic [7:0] i_array_data, // Array byte at o_addr
    output logic o_so, // Serial data out
    output logic o_so_oe, // Data out enable
    output logic o_paused, // Pause state
    output logic [23:0] o_addr, // Current address
    output logic [5:0] o_sector, // Sector of o_addr
    output logic o_read_strobe, // Array byte consumed
    output logic [7:0] o_data_byte, // Last data byte in
    output logic o_data_strobe, // Data byte received
    output logic o_exec, // Command executes
    output logic [7:0] o_opcode, // Current opcode
    output logic o_exec_accel, // Exec under accel voltage
    output logic o_write_enable_latch, // Write enable latch
    output logic o_param_sector, // Parameter sector selected
    output logic o_parallel_mode, // Parallel mode entered
    output logic o_sleep // Deep power-down
);
    // ----------------------------------------------------------------
    // Decode functions
    // ----------------------------------------------------------------
    function automatic logic [2:0] hdr_len(input logic [7:0] op);
        case (op)
            CMD_READ, CMD_PAGE_WRITE, CMD_WAKE,
            CMD_SECTOR_WIPE_A, CMD_SECTOR_WIPE_B,
            CMD_MAKER_DEVICE_IDENTITY: hdr_len = HDR_ADDR; // [RULE13]
            CMD_FAST_READ: hdr_len = HDR_FAST; // [RULE10]
            default: hdr_len = HDR_NONE;
        endcase
    endfunction

    function automatic logic is_out(input logic [7:0] op);
        case (op)
            CMD_IDENTITY_READ, CMD_STATUS_READ, CMD_READ,
            CMD_FAST_READ, CMD_WAKE,
            CMD_MAKER_DEVICE_IDENTITY: is_out = 1'b1;
            default: is_out = 1'b0;
        endcase
    endfunction

    function automatic logic is_mod(input logic [7:0] op);
        case (op)
            CMD_STATUS_WRITE, CMD_PAGE_WRITE, CMD_SECTOR_WIPE_A,
            CMD_SECTOR_WIPE_B, CMD_CHIP_WIPE_A,
            CMD_CHIP_WIPE_B: is_mod = 1'b1; // [RULE11]
            default: is_mod = 1'b0;
        endcase
    endfunction

    function automatic logic op_known(input logic [7:0] op,
                                      input logic slp,
                                      input logic bsy);
        if (slp) begin
            op_known = (op == CMD_WAKE);
        end else if (bsy) begin
            op_known = (op == CMD_STATUS_READ);
        end else begin
            op_known = is_out(op) || is_mod(op) ||
                (op == CMD_WRITE_LATCH_SET) ||
                (op == CMD_WRITE_LATCH_CLEAR) ||
                (op == CMD_PARALLEL) || (op == CMD_SLEEP) ||
                (op == CMD_PARAM_SECTOR_ENTER) ||
                (op == CMD_PARAM_SECTOR_EXIT);
        end
    endfunction

    // Byte shape a command must have when select rises
    function automatic logic shape_ok(input logic [7:0] op,
                                      input sfh_state_t st,
                                      input logic [2:0] hc,
                                      input logic [1:0] dc);
        case (op)
            CMD_STATUS_WRITE: shape_ok = (st == ST_IN) && (dc == 2'h1);
            CMD_PAGE_WRITE: shape_ok = (st == ST_IN) && (dc != 2'h0);
            CMD_WAKE: shape_ok = (st == ST_HDR) && (hc == HDR_NONE);
            CMD_WRITE_LATCH_SET, CMD_WRITE_LATCH_CLEAR, CMD_PARALLEL,
            CMD_SECTOR_WIPE_A, CMD_SECTOR_WIPE_B, CMD_CHIP_WIPE_A,
            CMD_CHIP_WIPE_B, CMD_SLEEP, CMD_PARAM_SECTOR_ENTER,
            CMD_PARAM_SECTOR_EXIT: shape_ok = (st == ST_IN) && (dc == 2'h0);
            default: shape_ok = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    sfh_pins_if #(.N(PIN_COUNT)) pins();

    sfh_pin_sync #(.N(PIN_COUNT)) u_sync (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_pins({i_protect_accel_pin, i_pause_n, i_si, i_sclk, i_cs_n}),
        .pins(pins)
    );

    sfh_state_t state;
    sfh_state_t next_state;
    logic paused;
    logic armed;
    logic [6:0] in_sh;
    logic [2:0] bit_cnt;
    logic [2:0] hdr_cnt;
    logic [1:0] data_cnt;
    logic [6:0] out_sh;
    logic [2:0] out_cnt;
    logic [1:0] out_idx;
    logic order;

    wire cs_hi = pins.lvl[PIN_CS];
    wire cs_rise = pins.rise[PIN_CS];
    wire sclk_hi = pins.lvl[PIN_SCLK];
    wire pause_hi = pins.lvl[PIN_PAUSE];
    wire accel_hi = pins.lvl[PIN_ACCEL];

    // ----------------------------------------------------------------
    // Pause control
    // ----------------------------------------------------------------
    wire enter = armed && !paused && !pause_hi && !sclk_hi; // [RULE2]
    wire leave = paused && pause_hi && !sclk_hi; // [RULE3]
    // Entry needs a fresh falling edge, so a pause held low across select
    // cannot re-enter by itself
    wire next_armed = !cs_hi && (pins.fall[PIN_PAUSE] ||
        (armed && !pause_hi && !enter)); // [RULE2] [RULE6]
    wire next_paused = !cs_hi && (enter || (paused && !leave)); // [RULE5]

    // Serial clock edges only count while selected and not paused
    wire active = !cs_hi && !paused; // [RULE4]
    wire sck_rise = active && pins.rise[PIN_SCLK]; // [RULE16]
    wire sck_fall = active && pins.fall[PIN_SCLK]; // [RULE16]
    wire [7:0] byte_in = {in_sh, pins.lvl[PIN_SI]}; // [RULE18]
    wire byte_done = sck_rise && (bit_cnt == 3'h7);
    wire [2:0] next_bit = cs_hi ? 3'h0 : (sck_rise ? bit_cnt + 3'h1 : bit_cnt);

    // ----------------------------------------------------------------
    // Output byte selection
    // ----------------------------------------------------------------
    wire identity_read_cmd_sel = (o_opcode == CMD_IDENTITY_READ);
    wire array_rd = (o_opcode == CMD_READ) || (o_opcode == CMD_FAST_READ);
    wire maker_first = (out_idx[0] == order); // [RULE14]
    wire [7:0] id_byte = (out_idx == 2'h0) ? MAKER_CODE :
        ((out_idx == 2'h1) ? DEVICE_TYPE : DEVICE_CODE);
    wire [7:0] out_src =
        (o_opcode == CMD_STATUS_READ) ? i_status :
        array_rd ? i_array_data :
        identity_read_cmd_sel ? id_byte : // [RULE9]
        (o_opcode == CMD_WAKE) ? SHORT_ID : // [RULE13]
        (maker_first ? MAKER_CODE : DEVICE_CODE); // [RULE14]
    wire load_out = sck_fall && (state == ST_OUT) && (out_cnt == 3'h0);
    wire [1:0] next_idx = (identity_read_cmd_sel && out_idx == 2'h2) ? 2'h0 :
        out_idx + 2'h1;
    // Reads wrap at the top of the array back to address zero
    wire [23:0] addr_inc = {2'b00, o_addr[21:0] + ADDR_STEP}; // [RULE15]

    // ----------------------------------------------------------------
    // Execution at deselect
    // ----------------------------------------------------------------
    wire wel_ok = !is_mod(o_opcode) || o_write_enable_latch;
    wire exec_ok = cs_rise && !paused && (bit_cnt == 3'h0) &&
        shape_ok(o_opcode, state, hdr_cnt, data_cnt) && wel_ok; // [RULE17]
    wire ex_set = exec_ok && (o_opcode == CMD_WRITE_LATCH_SET);
    wire ex_clr = exec_ok && (is_mod(o_opcode) ||
        o_opcode == CMD_WRITE_LATCH_CLEAR); // [RULE9]

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    logic [2:0] next_hdr;
    logic [1:0] next_data;
    logic [7:0] next_op;
    logic [23:0] next_addr;
    logic next_order;
    logic [7:0] next_data_byte;
    logic next_data_strobe;

    always_comb begin
        next_state = state;
        next_hdr = hdr_cnt;
        next_data = data_cnt;
        next_op = o_opcode;
        next_addr = o_addr;
        next_order = order;
        next_data_byte = o_data_byte;
        next_data_strobe = 1'b0;
        case (state)
            ST_IDLE: begin
                next_state = ST_OPC;
                next_hdr = HDR_NONE;
                next_data = 2'h0;
            end
            ST_OPC: begin
                if (byte_done) begin
                    next_op = byte_in;
                    if (!op_known(byte_in, o_sleep, i_busy)) begin
                        next_state = ST_BAD; // [RULE19]
                    end else if (hdr_len(byte_in) != HDR_NONE) begin
                        next_state = ST_HDR;
                    end else if (is_out(byte_in)) begin
                        next_state = ST_OUT;
                    end else begin
                        next_state = ST_IN;
                    end
                end
            end
            ST_HDR: begin
                if (byte_done) begin
                    next_hdr = hdr_cnt + 3'h1;
                    if (hdr_cnt < HDR_ADDR) begin
                        next_addr = {o_addr[15:0], byte_in}; // [RULE18]
                    end
                    if (o_opcode == CMD_MAKER_DEVICE_IDENTITY) begin
                        next_order = (byte_in == ORDER_DEVICE_FIRST);
                    end
                    if (next_hdr == hdr_len(o_opcode)) begin
                        next_state = is_out(o_opcode) ? ST_OUT : ST_IN;
                    end
                end
            end
            ST_IN: begin
                if (byte_done) begin
                    next_data = (data_cnt == 2'h3) ? data_cnt :
                        data_cnt + 2'h1;
                    next_data_byte = byte_in;
                    next_data_strobe = (o_opcode == CMD_PAGE_WRITE) ||
                        (o_opcode == CMD_STATUS_WRITE);
                end
            end
            ST_OUT: begin
                if (load_out && array_rd) begin
                    next_addr = addr_inc; // [RULE10]
                end
            end
            ST_BAD: begin
                next_state = ST_BAD; // [RULE19]
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (cs_hi) begin
            next_state = ST_IDLE; // [RULE5]
        end
    end

    // Sequencer and shift-in registers
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            paused <= 1'b0;
            armed <= 1'b0;
            in_sh <= 7'h00;
            bit_cnt <= 3'h0;
            hdr_cnt <= HDR_NONE;
            data_cnt <= 2'h0;
            order <= 1'b0;
        end else begin
            state <= next_state;
            paused <= next_paused;
            armed <= next_armed;
            in_sh <= sck_rise ? byte_in[6:0] : in_sh;
            bit_cnt <= next_bit;
            hdr_cnt <= next_hdr;
            data_cnt <= next_data;
            order <= next_order;
        end
    end

    // Shift-out path, one bit per serial clock fall
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_so <= 1'b0;
            out_sh <= 7'h00;
            out_cnt <= 3'h0;
            out_idx <= 2'h0;
        end else if (cs_hi) begin
            out_cnt <= 3'h0;
            out_idx <= 2'h0;
        end else if (load_out) begin
            o_so <= out_src[7]; // [RULE18]
            out_sh <= out_src[6:0];
            out_cnt <= 3'h1;
            out_idx <= next_idx;
        end else if (sck_fall && state == ST_OUT) begin
            o_so <= out_sh[6]; // [RULE16]
            out_sh <= {out_sh[5:0], 1'b0};
            out_cnt <= out_cnt + 3'h1;
        end
    end

    // Bus-facing registers
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_so_oe <= 1'b0;
            o_paused <= 1'b0;
            o_addr <= ADDR_RESET;
            o_sector <= 6'h00;
            o_read_strobe <= 1'b0;
            o_data_byte <= BYTE_RESET;
            o_data_strobe <= 1'b0;
            o_opcode <= BYTE_RESET;
        end else begin
            o_so_oe <= (next_state == ST_OUT) && !next_paused; // [RULE4]
            o_paused <= next_paused;
            o_addr <= next_addr;
            o_sector <= next_addr[SECTOR_MSB:SECTOR_LSB]; // [RULE15]
            o_read_strobe <= load_out && array_rd;
            o_data_byte <= next_data_byte;
            o_data_strobe <= next_data_strobe;
            o_opcode <= next_op;
        end
    end

    // Mode flags; the busy input is never touched by pause
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_exec <= 1'b0;
            o_exec_accel <= 1'b0;
            o_write_enable_latch <= 1'b0;
            o_param_sector <= 1'b0;
            o_parallel_mode <= 1'b0;
            o_sleep <= 1'b0;
        end else begin
            o_exec <= exec_ok; // [RULE1]
            o_exec_accel <= exec_ok && accel_hi && is_mod(o_opcode); // [RULE8]
            o_write_enable_latch <= ex_set || (o_write_enable_latch &&
                !ex_clr); // [RULE9]
            if (exec_ok && o_opcode == CMD_PARAM_SECTOR_ENTER) begin
                o_param_sector <= 1'b1; // [RULE12]
            end else if (exec_ok && o_opcode == CMD_PARAM_SECTOR_EXIT) begin
                o_param_sector <= 1'b0; // [RULE12]
            end
            if (exec_ok && o_opcode == CMD_PARALLEL) begin
                o_parallel_mode <= 1'b1; // [RULE10]
            end
            if (exec_ok && o_opcode == CMD_SLEEP) begin
                o_sleep <= 1'b1; // [RULE12]
            end else if (exec_ok && o_opcode == CMD_WAKE) begin
                o_sleep <= 1'b0; // [RULE13]
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    property p_hiz_paused;
        paused && $past(paused) |-> !o_so_oe;
    endproperty
    a_hiz_paused: assert property (p_hiz_paused) // [RULE4]
        else $error("data out driven while paused");

    property p_enter_low;
        $rose(paused) |-> $past(!sclk_hi && !pause_hi && !cs_hi);
    endproperty
    a_enter_low: assert property (p_enter_low) // [RULE2]
        else $error("pause entered with clock or pause high");

    property p_leave_low;
        $fell(paused) |-> $past(cs_hi || (pause_hi && !sclk_hi));
    endproperty
    a_leave_low: assert property (p_leave_low) // [RULE3]
        else $error("pause left with clock high");

    property p_ignore;
        paused && !cs_hi |=> $stable(bit_cnt) && $stable(out_cnt);
    endproperty
    a_ignore: assert property (p_ignore) // [RULE4]
        else $error("serial clock counted during pause");

    property p_abandon;
        paused && cs_rise |=> !o_exec && state == ST_IDLE ##1 !o_paused;
    endproperty
    a_abandon: assert property (p_abandon) // [RULE5]
        else $error("command not dropped after deselect in pause");

    property p_boundary;
        o_exec |-> $past(bit_cnt) == 3'h0 && $past(cs_rise);
    endproperty
    a_boundary: assert property (p_boundary) // [RULE17]
        else $error("command ran off a byte boundary");

    property p_wel;
        o_exec && o_opcode == CMD_WRITE_LATCH_SET |-> o_write_enable_latch;
    endproperty
    a_wel: assert property (p_wel) // [RULE9]
        else $error("latch set command did not set the latch");

    property p_bad_quiet;
        state == ST_BAD |=> !o_so_oe && !o_exec;
    endproperty
    a_bad_quiet: assert property (p_bad_quiet) // [RULE19]
        else $error("unknown opcode produced activity");

    property p_sector;
        o_sector == o_addr[SECTOR_MSB:SECTOR_LSB];
    endproperty
    a_sector: assert property (p_sector) // [RULE15]
        else $error("sector does not match address");

    property p_order;
        load_out && o_opcode == CMD_MAKER_DEVICE_IDENTITY && out_idx == 2'h0
        |=> o_so == (order ? DEVICE_CODE[7] : MAKER_CODE[7]);
    endproperty
    a_order: assert property (p_order) // [RULE14]
        else $error("identity byte order wrong");
endmodule

// ---- test/sfh_host_model.sv ----
`timescale 1ns/1ns
module sfh_host_model (
    output logic o_cs_n, // Select to the device
    output logic o_sclk, // Serial clock, idle low
    output logic o_si, // Data to the device
    input wire logic i_so // Data from the device
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
    end
    // Select or release on a byte boundary; data flips after either
    task automatic sel(input logic s);
        #200 o_cs_n = ~s;
        o_si = ~o_si;
    endtask
    // One byte, MSB first, mode 0; input read late in the high phase
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_si = tx[i];
            #80 o_sclk = 1'b1;
            #70 rx[i] = i_so;
            #10 o_sclk = 1'b0;
        end
    endtask
endmodule

// ---- test/sfh_flash_front_test.sv ----
`timescale 1ns/1ns
module sfh_flash_front_test;
    import sfh_pkg::*;
    localparam logic [7:0] MK = 8'h5A, TY = 8'h11, DC = 8'h22;
    logic i_mclk = 0, i_reset_n = 0, i_pause_n = 1, accel = 0;
    logic cs_n, sclk, si, so, oe, paused, ex, write_enable_latch, psec, slp;
    logic [23:0] addr, a;
    logic [5:0] sector;
    logic [7:0] rx, dat = 0, op, ex_op = 0;
    logic [7:0] id[3] = '{MK, TY, DC};
    logic [7:0] wp[4] = '{CMD_SECTOR_WIPE_A, CMD_SECTOR_WIPE_B,
        CMD_CHIP_WIPE_A, CMD_CHIP_WIPE_B};
    logic [31:0] lfsr = 32'h0000_1b44;
    int failures = 0, compares = 0;
    always #10 i_mclk = ~i_mclk;
    // Data line floats high through a pull-up while the device lets go
    sfh_host_model host_u (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si),
        .i_so(oe ? so : 1'b1));
    sfh_flash_front #(.MAKER_CODE(MK), .DEVICE_TYPE(TY), .DEVICE_CODE(DC))
        dut_u (.i_mclk, .i_reset_n, .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si),
        .i_pause_n, .i_protect_accel_pin(accel), .i_busy(1'b0),
        .i_status(lfsr[7:0]), .i_array_data(dat), .o_so(so), .o_so_oe(oe),
        .o_paused(paused), .o_addr(addr), .o_sector(sector),
        .o_read_strobe(), .o_data_byte(), .o_data_strobe(), .o_exec(ex),
        .o_opcode(op), .o_exec_accel(), .o_write_enable_latch(write_enable_latch),
        .o_param_sector(psec), .o_parallel_mode(), .o_sleep(slp));
    // Array contents derived from the address; last executed opcode kept
    function automatic logic [7:0] dof(input logic [23:0] v);
        return v[7:0] ^ v[23:16] ^ 8'h5C;
    endfunction
    always @(negedge i_mclk) dat <= dof(addr);
    always @(posedge i_mclk) if (ex === 1'b1) ex_op <= op;
    task automatic chk(input string n, input logic [23:0] e, g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Opcode then n header bytes, address high byte first
    task automatic cmd(input logic [7:0] o, input int n);
        host_u.sel(1);
        host_u.xfer(o, rx);
        for (int i = 0; i < n; i++) host_u.xfer(i < 3 ? a[23-8*i -: 8] : 0, rx);
    endtask
    task automatic fin(input string n);
        host_u.sel(0);
        repeat (8) @(negedge i_mclk);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        $display("test %s done", n);
    endtask
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #2_000_000 failures++;
        print_verdict;
    end
    // Main sequence
    initial begin
        repeat (12) @(negedge i_mclk);
        i_reset_n = 1;
        repeat (4) @(negedge i_mclk);
        accel = 1;
        foreach (wp[i]) begin
            a = lfsr[23:0];
            cmd(CMD_WRITE_LATCH_SET, 0);
            fin("latch");
            chk("latch", 1, write_enable_latch);
            cmd(wp[i], i < 2 ? 3 : 0);
            fin("wipe");
            chk("wipe", wp[i], ex_op);
            chk("latch", 0, write_enable_latch);
        end
        for (int k = 0; k < 4; k++) begin
            a = k == 0 ? 24'h3F_FFFF : {2'b00, lfsr[21:0]};
            cmd(k[0] ? CMD_FAST_READ : CMD_READ, k[0] ? 4 : 3);
            chk("addr", a, addr);
            chk("sector", a[21:16], sector);
            host_u.xfer(0, rx);
            chk("rd0", dof(a), rx);
            host_u.xfer(0, rx);
            chk("rd1", dof((a + 1) & 24'h3F_FFFF), rx);
            fin("read");
        end
        cmd(CMD_IDENTITY_READ, 0);
        // Parallel mode is never entered, so pause is allowed here
        @(negedge i_mclk) i_pause_n = 0;
        repeat (8) @(negedge i_mclk);
        chk("paused", 1, paused);
        chk("oe", 0, oe);
        host_u.xfer(8'hFF, rx);
        @(negedge i_mclk) i_pause_n = 1;
        repeat (8) @(negedge i_mclk);
        chk("paused", 0, paused);
        foreach (id[i]) begin
            host_u.xfer(0, rx);
            chk("id", id[i], rx);
        end
        fin("pause");
        for (int o = 0; o < 2; o++) begin
            a = o;
            cmd(CMD_MAKER_DEVICE_IDENTITY, 3);
            host_u.xfer(0, rx);
            chk("order", o ? DC : MK, rx);
            host_u.xfer(0, rx);
            chk("order", o ? MK : DC, rx);
            fin("order");
        end
        cmd(CMD_STATUS_READ, 0);
        host_u.xfer(0, rx);
        chk("status", lfsr[7:0], rx);
        fin("status");
        cmd(CMD_PARAM_SECTOR_ENTER, 0);
        fin("param");
        chk("param", 1, psec);
        cmd(CMD_SLEEP, 0);
        fin("sleep");
        chk("sleep", 1, slp);
        cmd(CMD_WAKE, 0);
        fin("wake");
        chk("sleep", 0, slp);
        cmd(CMD_PARAM_SECTOR_EXIT, 0);
        fin("param");
        chk("param", 0, psec);
        cmd(8'hE7, 0);
        host_u.xfer(0, rx);
        chk("oe", 0, oe);
        chk("float", 8'hFF, rx);
        fin("unknown");
        cmd(CMD_WRITE_LATCH_SET, 0);
        @(negedge i_mclk) i_pause_n = 0;
        repeat (8) @(negedge i_mclk);
        fin("abort");
        chk("paused", 0, paused);
        chk("latch", 0, write_enable_latch);
        i_pause_n = 1;
        print_verdict;
    end
endmodule
